// File: core/hdlc_fifo_pkg.sv
// Constants shared by the HDLC FIFO host status block
package hdlc_fifo_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 64;
    localparam int LEVEL_W = 7;
    // Register offsets
    localparam logic [7:0] RX_BYTES_AVAIL_ADDR = 8'hB5;
    localparam logic [7:0] RX_LIVE_ADDR = 8'hB4;
    localparam logic [7:0] RX_STICKY_ADDR = 8'h94;
    localparam logic [7:0] RX_MASK_ADDR = 8'hA4;
    localparam logic [7:0] RX_WATERMARK_ADDR = 8'h87;
    localparam logic [7:0] TX_WATERMARK_ADDR = 8'h87;
    localparam logic [7:0] TX_LIVE_ADDR = 8'hB1;
    localparam logic [7:0] TX_STICKY_ADDR = 8'h91;
    localparam logic [7:0] TX_MASK_ADDR = 8'hA1;
    localparam logic [7:0] TX_SPACE_ADDR = 8'hB3;
    localparam logic [7:0] TX_LOW_WM_ADDR = 8'hC7;
    // Receive status bit positions
    localparam int RX_PKT_END_BIT = 0;
    localparam int RX_HIGH_WM_BIT = 1;
    localparam int RX_EMPTY_BIT = 2;
    localparam int RX_OVERRUN_BIT = 5;
    // Transmit status bit positions
    localparam int TX_LOW_WM_BIT = 0;
    localparam int TX_UNDERRUN_BIT = 1;
    localparam int TX_EMPTY_BIT = 2;
    // Reset values
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [6:0] RX_HIGH_WM_RESET = 7'h30;
    localparam logic [6:0] TX_LOW_WM_RESET = 7'h10;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// File: core/hdlc_status_if.sv
// Interface carrying one direction's status events between modules
`timescale 1ns/10ps
`default_nettype none
interface hdlc_status_if;
    logic [7:0] live;
    logic [7:0] event_set;
    logic [7:0] sticky;
    logic [7:0] mask;
    logic pending;
    modport core (output live, output event_set, input sticky, input pending);
    modport flags (input event_set, output sticky, input mask,
        output pending);
endinterface
`default_nettype wire

// File: core/hdlc_sticky_flags.sv
// Sticky status bits with write-one-to-clear and mask gating
`timescale 1ns/10ps
`default_nettype none
module hdlc_sticky_flags
    import hdlc_fifo_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Host clear
    input wire logic clear_we,
    input wire logic [7:0] clear_bits,
    // Status group
    hdlc_status_if.flags st
);
    logic [7:0] sticky_reg;
    logic [7:0] sticky_next;

    // Set wins over a clear arriving in the same cycle
    always_comb begin
        sticky_next = sticky_reg;
        if (clear_we) begin
            sticky_next = sticky_next & ~clear_bits;
        end
        sticky_next = sticky_next | st.event_set;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sticky_reg <= 8'h00;
        end else begin
            sticky_reg <= sticky_next;
        end
    end

    assign st.sticky = sticky_reg;
    assign st.pending = |(sticky_reg & st.mask);

    sticky_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        (!clear_we && !$past(reset_n) == 1'b0) |=>
        ((sticky_reg & $past(sticky_reg)) == $past(sticky_reg)))
        else $error("sticky bit dropped without clear");
    w1c_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
        (clear_we && ((clear_bits & st.event_set) == 8'h00)) |=>
        ((sticky_reg & $past(clear_bits)) == 8'h00))
        else $error("written one did not clear bit");
endmodule
`default_nettype wire

// File: core/hdlc_fifo_host_status.sv
// HDLC receive/transmit FIFO host status, flags and interrupt
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module hdlc_fifo_host_status
    import hdlc_fifo_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rd_data,
    // Receive FIFO data to host
    input wire logic rxf_rd_stb,
    output logic [7:0] rxf_rd_data,
    // Receive framer side
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_last,
    input wire logic rx_abort,
    // Transmit FIFO data from host
    input wire logic txf_wr_stb,
    input wire logic [7:0] txf_wr_data,
    // Transmit framer side
    input wire logic tx_byte_take,
    output logic [7:0] tx_byte,
    output logic tx_byte_valid,
    // Interrupt
    output logic irq_n_out
);
    ////////////////////////////////////////////////////////////////////
    // Receive FIFO, each entry tagged with end-of-packet
    logic [8:0] rx_mem [FIFO_DEPTH];
    logic [5:0] rx_wp_reg, rx_wp_next, rx_rp_reg, rx_rp_next;
    logic [LEVEL_W-1:0] rx_lvl_reg, rx_lvl_next;
    logic [LEVEL_W-1:0] seg_reg, seg_next;
    logic [7:0] rxf_rd_data_reg, rxf_rd_data_next;
    logic seg_end_reg, seg_end_next, in_drop_reg, in_drop_next;
    logic overrun_ev, pkt_end_ev, rx_push, rx_pop, eop_found;
    logic [LEVEL_W-1:0] eop_dist;

    assign rx_pop = rxf_rd_stb && (seg_reg != 7'h00);
    assign overrun_ev = rx_byte_valid && !in_drop_reg &&
        (rx_lvl_reg == 7'(FIFO_DEPTH)) && !rx_pop;
    assign rx_push = rx_byte_valid && !in_drop_reg && !overrun_ev;

    // Distance to the first stored end-of-packet beyond the read pointer
    always_comb begin
        eop_dist = rx_lvl_reg;
        eop_found = 1'b0;
        for (int i = FIFO_DEPTH - 1; i >= 0; i--) begin
            if ((7'(i) < rx_lvl_reg) && rx_mem[6'(rx_rp_reg + 6'(i))][8]) begin
                eop_dist = 7'(i + 1);
                eop_found = 1'b1;
            end
        end
    end

    always_comb begin
        rx_wp_next = rx_wp_reg;
        rx_rp_next = rx_rp_reg;
        rx_lvl_next = rx_lvl_reg;
        rxf_rd_data_next = rxf_rd_data_reg;
        in_drop_next = in_drop_reg;
        seg_next = seg_reg;
        seg_end_next = seg_end_reg;
        if (rx_push) begin
            rx_wp_next = rx_wp_reg + 6'h01;
        end
        if (rx_pop) begin
            rx_rp_next = rx_rp_reg + 6'h01;
            rxf_rd_data_next = rx_mem[rx_rp_reg][7:0];
            seg_next = seg_reg - 7'h01;
        end
        rx_lvl_next = rx_lvl_reg + 7'(rx_push) - 7'(rx_pop);
        // Open or spent segment follows the FIFO; an ended one holds
        if ((!seg_end_reg || seg_reg == 7'h00) && !rx_pop) begin
            seg_next = eop_dist;
            seg_end_next = eop_found;
        end
        if (rx_byte_valid && rx_byte_last) begin
            in_drop_next = 1'b0;
        end
        if (overrun_ev) begin
            rx_wp_next = 6'h00;
            rx_rp_next = 6'h00;
            rx_lvl_next = 7'h00;
            seg_next = 7'h00;
            in_drop_next = !rx_byte_last;
        end
    end

    always_ff @(posedge clock) begin
        if (rx_push) begin
            rx_mem[rx_wp_reg] <= {rx_byte_last || rx_abort, rx_byte};
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_wp_reg <= 6'h00;
            rx_rp_reg <= 6'h00;
            rx_lvl_reg <= 7'h00;
            rxf_rd_data_reg <= 8'h00;
            in_drop_reg <= 1'b0;
            seg_reg <= 7'h00;
            seg_end_reg <= 1'b0;
        end else begin
            rx_wp_reg <= rx_wp_next;
            rx_rp_reg <= rx_rp_next;
            rx_lvl_reg <= rx_lvl_next;
            rxf_rd_data_reg <= rxf_rd_data_next;
            in_drop_reg <= in_drop_next;
            seg_reg <= seg_next;
            seg_end_reg <= seg_end_next;
        end
    end
    assign rxf_rd_data = rxf_rd_data_reg;
    assign pkt_end_ev = rx_push && (rx_byte_last || rx_abort);

    ////////////////////////////////////////////////////////////////////
    // Transmit FIFO; the head register is one of its 64 bytes
    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [5:0] tx_wp_reg, tx_wp_next, tx_rp_reg, tx_rp_next;
    logic [LEVEL_W-1:0] tx_lvl_reg, tx_lvl_next, tx_fill;
    logic [7:0] tx_byte_reg, tx_byte_next;
    logic tx_valid_reg, tx_valid_next;
    logic tx_push, tx_pop, tx_under_ev;

    assign tx_fill = tx_lvl_reg + 7'(tx_valid_reg);
    assign tx_push = txf_wr_stb && (tx_fill != 7'(FIFO_DEPTH));
    assign tx_pop = (tx_lvl_reg != 7'h00) && (!tx_valid_reg || tx_byte_take);
    // Underrun is a take with nothing at the head
    assign tx_under_ev = tx_byte_take && !tx_valid_reg;

    always_comb begin
        tx_wp_next = tx_wp_reg + 6'(tx_push);
        tx_rp_next = tx_rp_reg + 6'(tx_pop);
        tx_lvl_next = tx_lvl_reg + 7'(tx_push) - 7'(tx_pop);
        tx_byte_next = tx_byte_reg;
        tx_valid_next = tx_valid_reg;
        if (tx_pop) begin
            tx_byte_next = tx_mem[tx_rp_reg];
            tx_valid_next = 1'b1;
        end else if (tx_byte_take) begin
            tx_valid_next = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (tx_push) begin
            tx_mem[tx_wp_reg] <= txf_wr_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_wp_reg <= 6'h00;
            tx_rp_reg <= 6'h00;
            tx_lvl_reg <= 7'h00;
            tx_byte_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
        end else begin
            tx_wp_reg <= tx_wp_next;
            tx_rp_reg <= tx_rp_next;
            tx_lvl_reg <= tx_lvl_next;
            tx_byte_reg <= tx_byte_next;
            tx_valid_reg <= tx_valid_next;
        end
    end
    assign tx_byte = tx_byte_reg;
    assign tx_byte_valid = tx_valid_reg;

    ////////////////////////////////////////////////////////////////////
    // Status flags and interrupt
    hdlc_status_if rx_st ();
    hdlc_status_if tx_st ();
    logic [6:0] rx_hwm_reg, rx_hwm_next, tx_lwm_reg, tx_lwm_next;
    logic [7:0] rx_mask_reg, rx_mask_next, tx_mask_reg, tx_mask_next;
    logic irq_n_reg, irq_n_next, lwm_prev_reg, lwm_prev_next;

    // Live bits are combinational from FIFO state and the watermark registers
    always_comb begin
        rx_st.live = 8'h00;
        rx_st.live[RX_PKT_END_BIT] = seg_end_reg && (seg_reg != 7'h00);
        rx_st.live[RX_HIGH_WM_BIT] = rx_lvl_reg > rx_hwm_reg;
        rx_st.live[RX_EMPTY_BIT] = rx_lvl_reg == 7'h00;
        rx_st.live[RX_OVERRUN_BIT] = in_drop_reg;
        rx_st.event_set = 8'h00;
        rx_st.event_set[RX_PKT_END_BIT] = pkt_end_ev;
        rx_st.event_set[RX_OVERRUN_BIT] = overrun_ev;
        tx_st.live = 8'h00;
        lwm_prev_next = tx_fill < tx_lwm_reg;
        tx_st.live[TX_LOW_WM_BIT] = lwm_prev_next;
        tx_st.live[TX_EMPTY_BIT] = tx_fill == 7'h00;
        tx_st.event_set = 8'h00;
        tx_st.event_set[TX_LOW_WM_BIT] = lwm_prev_next && !lwm_prev_reg;
        tx_st.event_set[TX_UNDERRUN_BIT] = tx_under_ev;
    end
    assign rx_st.mask = rx_mask_reg;
    assign tx_st.mask = tx_mask_reg;

    hdlc_sticky_flags rx_flags (
        .clock(clock),
        .reset_n(reset_n),
        .clear_we(wr_stb && addr == RX_STICKY_ADDR),
        .clear_bits(wr_data),
        .st(rx_st)
    );
    hdlc_sticky_flags tx_flags (
        .clock(clock),
        .reset_n(reset_n),
        .clear_we(wr_stb && addr == TX_STICKY_ADDR),
        .clear_bits(wr_data),
        .st(tx_st)
    );

    ////////////////////////////////////////////////////////////////////
    // Register port
    logic [7:0] rd_data_reg, rd_data_next;

    always_comb begin
        rx_mask_next = rx_mask_reg;
        tx_mask_next = tx_mask_reg;
        rx_hwm_next = rx_hwm_reg;
        tx_lwm_next = tx_lwm_reg;
        rd_data_next = rd_data_reg;
        if (wr_stb) begin
            case (addr)
                RX_MASK_ADDR: rx_mask_next = wr_data;
                TX_MASK_ADDR: tx_mask_next = wr_data;
                RX_WATERMARK_ADDR: rx_hwm_next = wr_data[6:0];
                TX_LOW_WM_ADDR: tx_lwm_next = wr_data[6:0];
                default: ;
            endcase
        end
        if (rd_stb) begin
            // Sampled once into a flop, so the value holds for the read
            case (addr)
                RX_BYTES_AVAIL_ADDR: rd_data_next =
                    {(seg_reg != 7'h00) && !seg_end_reg, seg_reg};
                RX_LIVE_ADDR: rd_data_next = rx_st.live;
                RX_STICKY_ADDR: rd_data_next = rx_st.sticky;
                RX_MASK_ADDR: rd_data_next = rx_mask_reg;
                TX_LIVE_ADDR: rd_data_next = tx_st.live;
                TX_STICKY_ADDR: rd_data_next = tx_st.sticky;
                TX_MASK_ADDR: rd_data_next = tx_mask_reg;
                TX_SPACE_ADDR: rd_data_next =
                    {1'b0, 7'(FIFO_DEPTH) - tx_fill};
                TX_LOW_WM_ADDR: rd_data_next = {1'b0, tx_lwm_reg};
                default: rd_data_next = UNMAPPED_READ;
            endcase
        end
        irq_n_next = !(rx_st.pending || tx_st.pending);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_mask_reg <= MASK_RESET;
            tx_mask_reg <= MASK_RESET;
            rx_hwm_reg <= RX_HIGH_WM_RESET;
            tx_lwm_reg <= TX_LOW_WM_RESET;
            rd_data_reg <= 8'h00;
            irq_n_reg <= 1'b1;
            lwm_prev_reg <= 1'b0;
        end else begin
            rx_mask_reg <= rx_mask_next;
            tx_mask_reg <= tx_mask_next;
            rx_hwm_reg <= rx_hwm_next;
            tx_lwm_reg <= tx_lwm_next;
            rd_data_reg <= rd_data_next;
            irq_n_reg <= irq_n_next;
            lwm_prev_reg <= lwm_prev_next;
        end
    end
    assign rd_data = rd_data_reg;
    assign irq_n_out = irq_n_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence overrun_s;
        overrun_ev;
    endsequence
    sequence flushed_s;
        (rx_lvl_reg == 7'h00) && rx_st.sticky[RX_OVERRUN_BIT];
    endsequence

    rx_count_range_a: assert property (@(posedge clock) disable iff (!reset_n)
        seg_reg <= 7'(FIFO_DEPTH) && seg_reg <= rx_lvl_reg)
        else $error("receive count out of range");
    overrun_flush_a: assert property (@(posedge clock) disable iff (!reset_n)
        overrun_s |=> flushed_s)
        else $error("overrun did not flush and flag");
    irq_assert_a: assert property (@(posedge clock) disable iff (!reset_n)
        (rx_st.pending || tx_st.pending) |=> !irq_n_out)
        else $error("unmasked event did not raise irq");
    irq_release_a: assert property (@(posedge clock) disable iff (!reset_n)
        (!rx_st.pending && !tx_st.pending) |=> irq_n_out)
        else $error("irq held with nothing pending");
    space_read_a: assert property (@(posedge clock) disable iff (!reset_n)
        (rd_stb && addr == TX_SPACE_ADDR) |=>
        rd_data == {1'b0, 7'(FIFO_DEPTH) - $past(tx_fill)})
        else $error("buffer space read wrong");
    low_wm_live_a: assert property (@(posedge clock) disable iff (!reset_n)
        tx_st.live[TX_LOW_WM_BIT] ==
        ((8'(tx_lvl_reg) + 8'(tx_valid_reg)) < {1'b0, tx_lwm_reg}))
        else $error("low watermark flag wrong");
    msb_read_a: assert property (@(posedge clock) disable iff (!reset_n)
        (rd_stb && addr == RX_BYTES_AVAIL_ADDR && $past(seg_end_reg) == 1'b1
        && seg_end_reg) |=> !rd_data[7])
        else $error("ended packet reported open");
    live_write_a: assert property (@(posedge clock) disable iff (!reset_n)
        (wr_stb && addr == RX_LIVE_ADDR && !rx_push && !rx_pop) |=>
        $stable(rx_lvl_reg))
        else $error("write disturbed live state");
endmodule
`default_nettype wire

// File: testbench/framer_model.sv
// Framer-side model: feeds receive bytes and drains transmit bytes
`timescale 1ns/10ps
`default_nettype none
module framer_model (
    // Clock
    input wire logic clock,
    // Receive bytes toward the block
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic rx_byte_last,
    output logic rx_abort,
    // Transmit bytes from the block
    input wire logic [7:0] tx_byte,
    input wire logic tx_byte_valid,
    output logic tx_byte_take,
    // Drain enable
    input wire logic take_en
);
    logic [7:0] taken[$];
    initial begin
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
        rx_byte_last = 1'b0;
        rx_abort = 1'b0;
        tx_byte_take = 1'b0;
    end
    // One byte every other cycle; data line scrambled while idle
    task automatic send(input int n, input logic last, input logic [7:0] b);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            rx_byte_valid <= 1'b1;
            rx_byte <= b + 8'(i);
            rx_byte_last <= last && (i == n - 1);
            @(posedge clock);
            rx_byte_valid <= 1'b0;
            rx_byte_last <= 1'b0;
            rx_byte <= ~rx_byte;
        end
    endtask
    // Gap after each take so the registered head can refresh
    always @(posedge clock) begin
        if (tx_byte_take) begin
            tx_byte_take <= 1'b0;
        end else if (take_en && tx_byte_valid === 1'b1) begin
            tx_byte_take <= 1'b1;
            taken.push_back(tx_byte);
        end
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the HDLC FIFO host status block
`timescale 1ns/10ps
`default_nettype none
module testbench
    import hdlc_fifo_pkg::*;
;
    logic clock, reset_n, wr_stb, rd_stb, rxf_rd_stb, txf_wr_stb, take_en;
    logic [7:0] addr, wr_data, rd_data, rxf_rd_data, txf_wr_data, tx_byte;
    logic [7:0] rx_byte, v, v1;
    logic rx_byte_valid, rx_byte_last, rx_abort, tx_byte_take;
    logic tx_byte_valid, irq_n_out;
    int num_errors = 0;
    int num_checks = 0;

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    hdlc_fifo_host_status dut (.clock(clock), .reset_n(reset_n),
        .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rd_data(rd_data), .rxf_rd_stb(rxf_rd_stb),
        .rxf_rd_data(rxf_rd_data), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte), .rx_byte_last(rx_byte_last),
        .rx_abort(rx_abort), .txf_wr_stb(txf_wr_stb),
        .txf_wr_data(txf_wr_data), .tx_byte_take(tx_byte_take),
        .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
        .irq_n_out(irq_n_out));

    framer_model fm (.clock(clock), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte), .rx_byte_last(rx_byte_last),
        .rx_abort(rx_abort), .tx_byte(tx_byte),
        .tx_byte_valid(tx_byte_valid), .tx_byte_take(tx_byte_take),
        .take_en(take_en));

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("Checks made %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask

    // Read data stand from the cycle after the strobe until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic txw(input logic [7:0] d);
        @(posedge clock);
        txf_wr_data <= d;
        txf_wr_stb <= 1'b1;
        @(posedge clock);
        txf_wr_stb <= 1'b0;
    endtask

    task automatic pop(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            rxf_rd_stb <= 1'b1;
            @(posedge clock);
            rxf_rd_stb <= 1'b0;
            #1 chk(rxf_rd_data, b + 8'(i));
        end
    endtask

    // Bounded wait for the interrupt level; a miss counts once
    task automatic wait_irq(input logic exp);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            #1;
            if (irq_n_out === exp) begin
                chk({7'h00, irq_n_out}, {7'h00, exp});
                return;
            end
        end
        chk({7'h00, irq_n_out}, {7'h00, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        rxf_rd_stb = 1'b0;
        txf_wr_stb = 1'b0;
        txf_wr_data = 8'h00;
        take_en = 1'b0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        rd(TX_SPACE_ADDR, v); chk(v, 8'h40);
        rd(RX_BYTES_AVAIL_ADDR, v); chk(v, 8'h00);
        rd(8'h00, v); chk(v, UNMAPPED_READ);
        rd(TX_STICKY_ADDR, v); chk(v & 8'h01, 8'h01);
        chk({7'h00, irq_n_out}, 8'h01);
        // Transmit path: space follows the level both ways
        for (int i = 0; i < 3; i++) txw(8'hA0 + 8'(i));
        rd(TX_SPACE_ADDR, v); chk(v, 8'h3D);
        take_en <= 1'b1;
        idle(20);
        take_en <= 1'b0;
        chk(8'(fm.taken.size()), 8'h03);
        for (int i = 0; i < 3; i++) chk(fm.taken[i], 8'hA0 + 8'(i));
        rd(TX_SPACE_ADDR, v); chk(v, 8'h40);
        rd(TX_LIVE_ADDR, v); chk(v, 8'h05);
        rd(TX_STICKY_ADDR, v); chk(v & 8'h02, 8'h00);
        for (int i = 0; i < 16; i++) txw(8'(i));
        rd(TX_LIVE_ADDR, v); chk(v & 8'h01, 8'h00);
        wr(TX_MASK_ADDR, 8'h01);
        wait_irq(1'b0);
        wr(TX_STICKY_ADDR, 8'h01);
        wait_irq(1'b1);
        wr(TX_MASK_ADDR, 8'h00);
        take_en <= 1'b1;
        idle(40);
        take_en <= 1'b0;
        // Receive segments: open part, then two packets queued
        fm.send(5, 1'b0, 8'h10);
        idle(3);
        rd(RX_BYTES_AVAIL_ADDR, v); chk(v, 8'h85);
        pop(5, 8'h10);
        fm.send(2, 1'b1, 8'h15);
        fm.send(3, 1'b1, 8'h20);
        idle(3);
        rd(RX_BYTES_AVAIL_ADDR, v); chk(v, 8'h02);
        pop(2, 8'h15);
        idle(3);
        rd(RX_BYTES_AVAIL_ADDR, v); chk(v, 8'h03);
        pop(3, 8'h20);
        idle(3);
        rd(RX_LIVE_ADDR, v1); chk(v1 & 8'h04, 8'h04);
        wr(RX_LIVE_ADDR, 8'hFF);
        rd(RX_LIVE_ADDR, v); chk(v, v1);
        // Host looks at status once the ended packet is drained
        rd(RX_STICKY_ADDR, v); chk(v & 8'h01, 8'h01);
        chk({7'h00, irq_n_out}, 8'h01);
        wr(RX_MASK_ADDR, 8'h01);
        wait_irq(1'b0);
        wr(RX_STICKY_ADDR, 8'h00);
        rd(RX_STICKY_ADDR, v); chk(v & 8'h01, 8'h01);
        wr(RX_STICKY_ADDR, 8'h01);
        wait_irq(1'b1);
        rd(RX_STICKY_ADDR, v); chk(v & 8'h01, 8'h00);
        // Full FIFO shows 64 open bytes; one more overruns
        wr(RX_MASK_ADDR, 8'h20);
        fm.send(64, 1'b0, 8'h40);
        idle(3);
        rd(RX_BYTES_AVAIL_ADDR, v); chk(v, 8'hC0);
        rd(RX_LIVE_ADDR, v); chk(v & 8'h02, 8'h02);
        fm.send(1, 1'b0, 8'h80);
        idle(3);
        rd(RX_STICKY_ADDR, v); chk(v & 8'h20, 8'h20);
        rd(RX_LIVE_ADDR, v); chk(v & 8'h24, 8'h24);
        rd(RX_BYTES_AVAIL_ADDR, v); chk(v, 8'h00);
        wait_irq(1'b0);
        fm.send(1, 1'b1, 8'h81);
        idle(3);
        rd(RX_LIVE_ADDR, v); chk(v & 8'h20, 8'h00);
        rd(RX_BYTES_AVAIL_ADDR, v); chk(v, 8'h00);
        wr(RX_STICKY_ADDR, 8'h20);
        wait_irq(1'b1);
        rd(RX_STICKY_ADDR, v); chk(v & 8'h20, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
